// File: sdpc_defs.vh
// Constants for the SDRAM pin command interface
`ifndef SDPC_DEFS_VH
`define SDPC_DEFS_VH

// =============================================
// Address space decode
`define SDPC_SPACE_HI 31
`define SDPC_SPACE_LO 30
`define SDPC_SPACE_SDRAM 2'h1
`define SDPC_SEL_HI 29
`define SDPC_SEL_LO 28

// =============================================
// Command codes {row, col, we}, active low
`define SDPC_CMD_NOP 3'h7
`define SDPC_CMD_ACT 3'h3
`define SDPC_CMD_RD 3'h5
`define SDPC_CMD_WR 3'h4
`define SDPC_CMD_PRE 3'h2
`define SDPC_CMD_REF 3'h1
`define SDPC_CMD_MRS 3'h0

// =============================================
// Request kinds on the command port
`define SDPC_REQ_ACT 3'h0
`define SDPC_REQ_RD 3'h1
`define SDPC_REQ_WR 3'h2
`define SDPC_REQ_PRE 3'h3
`define SDPC_REQ_REF 3'h4
`define SDPC_REQ_MRS 3'h5
`define SDPC_REQ_PDN 3'h6

`endif

// File: sdpc_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module sdpc_sync
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Async input and filtered level
   input wire din,
   output reg dout
);

   reg s1_r;
   reg s2_r;
   reg s3_r;

   // =============================================
   // Change counts once stages two and three agree
   always @(posedge clk)
   begin
      if (rst)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         dout <= 1'b0;
      end
      else
      begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            dout <= s3_r;
      end
   end

endmodule // sdpc_sync

`default_nettype wire

// File: sdpc_top.v
// SDRAM command and control pin driver with host handover
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_defs.vh"

module sdpc_top
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Ownership and host arbitration
   input wire bus_owner,
   input wire host_bus_request,
   output reg host_bus_grant,
   output reg host_bus_grant_oe,
   // Command request
   input wire req_valid,
   input wire [2:0] req_kind,
   input wire [31:0] req_addr,
   input wire req_a10,
   input wire req_mask,
   output reg req_ready,
   // SDRAM command pins
   output reg [3:0] sdram_space_selects_n,
   output reg ras_n,
   output reg cas_n,
   output reg sdram_write_strobe_n,
   output reg low_word_data_mask,
   output reg dedicated_row_addr_bit10,
   output reg sdram_clock_enable_out,
   output reg ctrl_oe
);

   // One-hot handover states
   localparam [4:0] ST_RUN = 5'h01;
   localparam [4:0] ST_SREF = 5'h02;
   localparam [4:0] ST_FLOAT = 5'h04;
   localparam [4:0] ST_GRANT = 5'h08;
   localparam [4:0] ST_WAKE = 5'h10;

   // Synchronised host request and handover state
   wire hreq_s;
   reg [4:0] state_r;
   reg [4:0] state_nxt;
   reg pdn_r;
   reg [2:0] cmd;
   reg [3:0] sel_nxt;
   reg issue;

   // =============================================
   // Host request arrives from a pin
   sdpc_sync u_hreq
   (
      .clk(clk),
      .rst(rst),
      .din(host_bus_request),
      .dout(hreq_s)
   );

   // =============================================
   // Select decode; top of the space is reserved
   function [3:0] sel_dec;
      input [31:0] a;
      begin
         sel_dec = 4'hf;
         if (a[`SDPC_SPACE_HI:`SDPC_SPACE_LO] == `SDPC_SPACE_SDRAM &&
             a[`SDPC_SEL_HI:`SDPC_SEL_LO] != 2'h3)
            sel_dec = ~(4'h1 << a[`SDPC_SEL_HI:`SDPC_SEL_LO]);
      end
   endfunction

   // Standard command table
   function [2:0] cmd_of;
      input [2:0] k;
      begin
         case (k)
            `SDPC_REQ_ACT: cmd_of = `SDPC_CMD_ACT;
            `SDPC_REQ_RD: cmd_of = `SDPC_CMD_RD;
            `SDPC_REQ_WR: cmd_of = `SDPC_CMD_WR;
            `SDPC_REQ_PRE: cmd_of = `SDPC_CMD_PRE;
            `SDPC_REQ_REF: cmd_of = `SDPC_CMD_REF;
            `SDPC_REQ_MRS: cmd_of = `SDPC_CMD_MRS;
            default: cmd_of = `SDPC_CMD_NOP;
         endcase
      end
   endfunction

   // Decoded more than once: an issued request of one kind
   function kind_hit;
      input iss;
      input [2:0] k;
      input [2:0] want;
      begin
         kind_hit = iss && k == want;
      end
   endfunction

   // =============================================
   // Handover sequence
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN:
            if (hreq_s && bus_owner)
               state_nxt = ST_SREF;
         ST_SREF:
            state_nxt = ST_FLOAT;
         ST_FLOAT:
            state_nxt = ST_GRANT;
         ST_GRANT:
            // Host keeps the bus while its request stands
            if (!hreq_s)
               state_nxt = ST_WAKE;
         ST_WAKE:
            state_nxt = ST_RUN;
         default:
            state_nxt = ST_RUN;
      endcase
   end

   always @*
   begin
      // Refused outside RUN, without the bus or with a host waiting
      issue = state_r == ST_RUN && req_valid && bus_owner && !hreq_s;
      cmd = issue ? cmd_of(req_kind) : `SDPC_CMD_NOP;
      sel_nxt = issue ? sel_dec(req_addr) : 4'hf;
      if (state_r == ST_SREF)
      begin
         // Self-refresh entry is a refresh with clock enable low
         cmd = `SDPC_CMD_REF;
         sel_nxt = 4'h0;
      end
   end

   // =============================================
   // Registered command pins
   always @(posedge clk)
   begin
      if (rst)
      begin
         ras_n <= 1'b1;
         cas_n <= 1'b1;
         sdram_write_strobe_n <= 1'b1;
         sdram_space_selects_n <= 4'hf;
         low_word_data_mask <= 1'b0;
         dedicated_row_addr_bit10 <= 1'b0;
      end
      else
      begin
         {ras_n, cas_n, sdram_write_strobe_n} <= cmd;
         // Foreign or reserved addresses issue with no select
         sdram_space_selects_n <= sel_nxt;
         // Mask only with a write column command
         low_word_data_mask <= kind_hit(issue, req_kind, `SDPC_REQ_WR) &&
                               req_mask;
         dedicated_row_addr_bit10 <= issue ? req_a10 : 1'b0;
      end
   end

   // =============================================
   // Power-down lasts until the next issued command or a host handover
   always @(posedge clk)
   begin
      if (rst)
      begin
         pdn_r <= 1'b0;
         sdram_clock_enable_out <= 1'b1;
      end
      else
      begin
         if (kind_hit(issue, req_kind, `SDPC_REQ_PDN))
            pdn_r <= 1'b1;
         // Any other issued command wakes the clock
         else if (issue || state_r != ST_RUN)
            pdn_r <= 1'b0;
         // Low through self-refresh and the whole grant
         sdram_clock_enable_out <= !(state_r == ST_SREF ||
            state_r == ST_FLOAT || state_r == ST_GRANT ||
            kind_hit(issue, req_kind, `SDPC_REQ_PDN) ||
            (pdn_r && !issue));
      end
   end

   // =============================================
   // Handover and ownership outputs
   always @(posedge clk)
   begin
      if (rst)
      begin
         state_r <= ST_RUN;
         ctrl_oe <= 1'b0;
         host_bus_grant <= 1'b1;
         host_bus_grant_oe <= 1'b0;
         req_ready <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         ctrl_oe <= bus_owner && (state_nxt == ST_RUN ||
            state_nxt == ST_SREF || state_nxt == ST_FLOAT);
         // Grant and release of the pins share one edge
         host_bus_grant <= !(state_nxt == ST_GRANT);
         host_bus_grant_oe <= bus_owner;
         req_ready <= state_nxt == ST_RUN && bus_owner && !hreq_s;
      end
   end

endmodule // sdpc_top

`default_nettype wire

// File: sdpc_chk.sv
// Concurrent checks on the SDRAM command pins
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_defs.vh"
module sdpc_chk
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Request side
   input wire logic bus_owner,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_mask,
   input wire logic [2:0] req_kind,
   input wire logic [31:0] req_addr,
   // Pin side
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic sdram_write_strobe_n,
   input wire logic low_word_data_mask,
   input wire logic sdram_clock_enable_out,
   input wire logic host_bus_grant,
   input wire logic ctrl_oe,
   input wire logic [3:0] sdram_space_selects_n
);
   wire [2:0] cmd = {ras_n, cas_n, sdram_write_strobe_n};
   wire iss = req_valid && req_ready && bus_owner &&
      req_addr[31:30] == 2'h1;
   wire hit = iss && req_addr[29:28] != 2'h3;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_sel_one: assert property (hit && req_kind < 3'h3 |=>
      sdram_space_selects_n == ~(4'h1 << $past(req_addr[29:28])))
      else $error("select");
   chk_rsv_sel: assert property (iss && req_addr[29:28] == 2'h3 |=>
      sdram_space_selects_n == 4'hf) else $error("reserved");
   chk_rd_code: assert property (hit && req_kind == `SDPC_REQ_RD |=>
      cmd == `SDPC_CMD_RD && !low_word_data_mask) else $error("read");
   chk_wr_mask: assert property (hit && req_kind == `SDPC_REQ_WR &&
      req_mask |=> cmd == `SDPC_CMD_WR && low_word_data_mask)
      else $error("write");
   chk_act_code: assert property (hit && req_kind == `SDPC_REQ_ACT |=>
      cmd == `SDPC_CMD_ACT) else $error("activate");
   chk_owner_oe: assert property (!bus_owner |=> !ctrl_oe)
      else $error("owner");
   chk_mask_cas: assert property (low_word_data_mask |->
      cmd == `SDPC_CMD_WR) else $error("mask");
   chk_ref_code: assert property (hit && req_kind == `SDPC_REQ_REF |=>
      cmd == `SDPC_CMD_REF) else $error("refresh");
   chk_pdn_cke: assert property (hit && req_kind == `SDPC_REQ_PDN |=>
      !sdram_clock_enable_out) else $error("powerdown");
   chk_grant_float: assert property (!host_bus_grant |->
      !ctrl_oe && !sdram_clock_enable_out) else $error("grant");
   cover property (hit && req_kind == `SDPC_REQ_WR && req_mask);
   cover property (iss && req_addr[29:28] == 2'h3);
   cover property (!host_bus_grant);
   cover property ($rose(host_bus_grant));
endmodule // sdpc_chk
`default_nettype wire

// File: sdpc_mem.sv
// Behavioural SDRAM side: records the last selected command
`timescale 1ns/1ps
`default_nettype none
module sdpc_mem
(
   input wire logic clk,
   input wire logic oe,
   input wire logic [3:0] sel_n,
   input wire logic [2:0] cmd,
   output logic [2:0] last_cmd
);
   // Released pins sit at their pull-ups, so nothing is selected then
   always @(posedge clk)
      if (oe && sel_n != 4'hf)
         last_cmd <= cmd;
endmodule // sdpc_mem
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the SDRAM pin command interface
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_defs.vh"
module testbench;
   logic clk, rst, own, hreq, vld, a10_in, msk_in;
   logic [2:0] kind, last_cmd;
   logic [31:0] addr;
   wire gnt, gnt_oe, rdy, ras_n, cas_n, we_n, mask, a10, cke, oe;
   wire [3:0] sel_n;
   int bad_count, num_checks;
   sdpc_top uut (.clk(clk), .rst(rst), .bus_owner(own),
      .host_bus_request(hreq), .host_bus_grant(gnt),
      .host_bus_grant_oe(gnt_oe),
      .req_valid(vld), .req_kind(kind), .req_addr(addr), .req_a10(a10_in),
      .req_mask(msk_in), .req_ready(rdy), .sdram_space_selects_n(sel_n),
      .ras_n(ras_n), .cas_n(cas_n), .sdram_write_strobe_n(we_n),
      .low_word_data_mask(mask), .dedicated_row_addr_bit10(a10),
      .sdram_clock_enable_out(cke), .ctrl_oe(oe));
   sdpc_mem mem (.clk(clk), .oe(oe), .sel_n(sel_n),
      .cmd({ras_n, cas_n, we_n}), .last_cmd(last_cmd));
   task automatic chk(input logic [31:0] g, e);
      num_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task end_of_test;
      $display("checks=%0d errors=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task go(input logic [2:0] k, input logic [31:0] a);
      vld = 1'h1;
      kind = k;
      addr = a;
      @(negedge clk);
   endtask
   task wait_rdy;
      for (int i = 0; i < 40 && rdy !== 1'h1; i++)
         @(negedge clk);
   endtask
   // =============================================
   // Scenarios
   task automatic t_cmds;
      logic [2:0] ec [6] = '{3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
      wait_rdy;
      for (int k = 0; k < 6; k++)
      begin
         a10_in = k[0];
         go(k[2:0], {2'h1, 2'(k % 3), 28'h0});
         chk({ras_n, cas_n, we_n}, ec[k]);
         chk(mask, k == 2);
         chk(a10, k[0]);
         if (k < 3)
            chk(sel_n, 4'(~(4'h1 << k)));
      end
      vld = 1'h0;
      @(negedge clk);
      chk({last_cmd, ras_n, cas_n, we_n}, 6'h07);
   endtask
   task t_rsv_pdn;
      wait_rdy;
      go(`SDPC_REQ_RD, 32'h7000_0000);
      chk(sel_n, 4'hf);
      go(`SDPC_REQ_PDN, 32'h8000_0000);
      chk(sel_n, 4'hf);
      go(`SDPC_REQ_PDN, 32'h4000_0000);
      chk(cke, 1'h0);
      go(`SDPC_REQ_RD, 32'h4000_0000);
      chk(cke, 1'h1);
      msk_in = 1'h0;
      go(`SDPC_REQ_WR, 32'h5000_0000);
      chk({mask, ras_n, cas_n, we_n, sel_n}, 8'h4d);
      msk_in = 1'h1;
      own = 1'h0;
      go(`SDPC_REQ_RD, 32'h4000_0000);
      chk({gnt_oe, oe, sel_n}, 6'h0f);
      vld = 1'h0;
      own = 1'h1;
   endtask
   task t_host;
      hreq = 1'h1;
      for (int i = 0; i < 40 && gnt !== 1'h0; i++)
         @(negedge clk);
      chk({gnt, oe, cke, last_cmd}, {3'h0, `SDPC_CMD_REF});
      hreq = 1'h0;
      wait_rdy;
      chk({gnt, oe, cke}, 3'h7);
   endtask
   task t_reset;
      vld = 1'h0;
      rst = 1'h1;
      @(negedge clk);
      chk({rdy, gnt_oe, oe, cke, gnt, mask, a10}, 7'h0c);
      chk({ras_n, cas_n, we_n, sel_n}, 7'h7f);
      rst = 1'h0;
      @(negedge clk);
      chk({rdy, gnt_oe, oe, gnt, cke}, 5'h1f);
   endtask
   initial
   begin
      clk = 1'h0;
      forever
         #4 clk = ~clk;
   end
   initial
   begin
      {rst, own, hreq, vld, a10_in, msk_in} = 6'h33;
      kind = 3'h7;
      addr = 32'h0;
      repeat (4) @(negedge clk);
      rst = 1'h0;
      t_cmds;
      t_rsv_pdn;
      t_host;
      t_reset;
      t_cmds;
      end_of_test;
   end
   // Whole run needs well under 300 cycles
   initial
   begin
      #20000;
      bad_count++;
      end_of_test;
   end
endmodule // testbench
bind sdpc_top sdpc_chk chk (.clk(clk), .rst(rst), .bus_owner(bus_owner),
   .req_valid(req_valid), .req_ready(req_ready), .req_mask(req_mask),
   .ras_n(ras_n), .cas_n(cas_n), .ctrl_oe(ctrl_oe),
   .sdram_write_strobe_n(sdram_write_strobe_n),
   .low_word_data_mask(low_word_data_mask),
   .sdram_clock_enable_out(sdram_clock_enable_out),
   .host_bus_grant(host_bus_grant), .req_kind(req_kind),
   .req_addr(req_addr), .sdram_space_selects_n(sdram_space_selects_n));
`default_nettype wire
